// >>> design/sfp_defs.svh
// Opcodes, status field positions, reset values and timing counts of the flash command interpreter.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// Command opcodes.
`define SFP_READ_CMD            8'h03
`define SFP_PROG_CMD            8'h02
`define SFP_READ_STATUS_CMD     8'h05
`define SFP_WRITE_STATUS_CMD    8'h01
`define SFP_WRITE_EN_CMD        8'h06
`define SFP_WRITE_DIS_CMD       8'h04
`define SFP_READ_IDENTITY_CMD   8'h9f
`define SFP_WAKE_SIG_CMD        8'hab
`define SFP_MAKER_DEV_ID_CMD    8'h90
`define SFP_DEEP_SLEEP_CMD      8'hb9
`define SFP_SECT_ERASE_A_CMD    8'h20
`define SFP_SECT_ERASE_B_CMD    8'hd8
`define SFP_CHIP_ERASE_A_CMD    8'h60
`define SFP_CHIP_ERASE_B_CMD    8'hc7
`define SFP_PARALLEL_CMD        8'h55
`define SFP_ENTER_PARAM_CMD     8'ha5
`define SFP_EXIT_PARAM_CMD      8'hb5

// Status register field positions and reset value.
`define SFP_ST_BUSY             0
`define SFP_ST_WEL              1
`define SFP_ST_BP_LO            2
`define SFP_ST_BP_HI            4
`define SFP_ST_FAIL             6
`define SFP_ST_LOCK             7
`define SFP_STATUS_RST          8'h00

// Internal operation time and system clock rate.
`define SFP_OP_TIME_US          3000
`define SFP_CLK_MHZ             10
`define SFP_OP_CYC              (`SFP_OP_TIME_US * `SFP_CLK_MHZ)

`endif

// >>> design/sfp_pkg.sv
// Types shared by the flash command interpreter.
`default_nettype none
package sfp_pkg;
   // Internal operations handed from the link to the sequencer.
   typedef enum logic [2:0]
   {
      SFP_OP_NONE   = 3'b000,
      SFP_OP_PROG   = 3'b001,
      SFP_OP_SERASE = 3'b010,
      SFP_OP_CERASE = 3'b011,
      SFP_OP_WSTAT  = 3'b100
   } sfp_op_t;

   // Sequencer states.
   typedef enum logic
   {
      SFP_IDLE = 1'b0,
      SFP_BUSY = 1'b1
   } sfp_seq_t;
endpackage
`default_nettype wire

// >>> design/sfp_flash_cmd.sv
// Flash command interpreter: link front end on the host clock, operation sequencer on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defs.svh"

// Behaviour
// - Parameter enter/exit ignored while busy
// - Parameter mode steers reads and writes
// - No chip erase or status write there
// - Chip erase spares parameter area
// - Fail bit set on failed operation
// - New write command clears fail bit
// - Parallel mode left only at power-off
// - Read data from fifth byte onward
// - Program data from fifth byte
// - Identity gives at most three bytes
// - Status/identity output enabled at eighth edge, first edge in parallel
// - Read-type output enabled one cycle early in serial mode
// - Status bit 7 locks status writes
// - Bits 4..2 protection level, 5 unused
// - Bit 1 is write-enable latch
// - Bit 0 shows busy
// - Address bit selects maker or device first
// - Signature command wakes, works in parallel
// - Status is zero after power-up
module sfp_flash_cmd
#(
   parameter int         OP_CYC   = `SFP_OP_CYC,
   parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value.
   parameter logic [7:0] MEM_TYPE = 8'h3c,  // Arbitrary value.
   parameter logic [7:0] DENSITY  = 8'h16,  // Arbitrary value.
   parameter logic [7:0] DEV_ID   = 8'h15   // Arbitrary value.
)
(
   // System clock and power-on reset.
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Link pins, clocked by the host.
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic        serial_out_or_parallel_bit7_i,
   output logic             serial_out_or_parallel_bit7_o,
   output logic             serial_out_or_parallel_bit7_oe,
   input  wire logic [6:0]  parallel_data_pins_i,
   output logic      [6:0]  parallel_data_pins_o,
   output logic      [6:0]  parallel_data_pins_oe,
   // Array access on the link clock.
   output logic      [23:0] arr_addr,
   output logic             arr_param,
   output logic             arr_rd,
   input  wire logic [7:0]  arr_rdata,
   output logic             arr_we,
   output logic      [7:0]  arr_wdata,
   // Operation sequencing on the system clock.
   output logic             op_start,
   output sfp_pkg::sfp_op_t op_kind,
   output logic             op_param,
   input  wire logic        op_fail,
   output logic             busy
);
   import sfp_pkg::*;

   // Power-on status byte, so the write-enable and fail flops take their own bits at full width.
   localparam logic [7:0] ST_RST = `SFP_STATUS_RST;

   // Status byte from its fields.
   function automatic logic [7:0] sfp_status(input logic lk, input logic fl, input logic [2:0] bp,
                                             input logic we, input logic bz);
      sfp_status = {lk, fl, 1'b0, bp, we, bz};
   endfunction

   // Commands whose output turns on a full cycle early.
   function automatic logic sfp_late_out(input logic [7:0] c);
      sfp_late_out = (c == `SFP_READ_CMD) || (c == `SFP_WAKE_SIG_CMD) || (c == `SFP_MAKER_DEV_ID_CMD);
   endfunction

   logic        frm_rst;
   logic [2:0]  bit_q;
   logic [2:0]  idx_q;
   logic [6:0]  sh_q;
   logic [7:0]  cmd_q;
   logic [23:0] addr_q;
   logic        wr_ok_q;
   logic [7:0]  dout_q;
   logic        oe_q;
   logic        so_bit_q;
   logic [1:0]  id_cnt_q;
   logic        alt_q;
   logic        par_q;
   logic        param_q;
   logic        wel_q;
   logic        lock_q;
   logic [2:0]  bp_q;
   logic        dp_q;
   logic        tog_q;
   sfp_op_t     kind_q;
   logic        kparam_q;
   logic        busy_m_q;
   logic        busy_s_q;
   logic        fail_m_q;
   logic        fail_s_q;
   logic [7:0]  in_byte;
   logic        byte_done;
   logic        arm;
   sfp_op_t     arm_kind;
   logic        maker_device_id_cmd_sel;
   logic        cs_m_q;
   logic        cs_s_q;
   logic        tog_m_q;
   logic        tog_s_q;
   logic        seen_q;
   sfp_seq_t    st_q;
   logic [23:0] cnt_q;
   logic        fail_q;
   logic        start_q;

   // ****************************************************************
   // Link front end
   // ****************************************************************

   // Deselect ends the frame, so per-frame state needs no link edge after it.
   assign frm_rst = sys_rst | cs_n;

   // Serial bytes assemble bit by bit; parallel bytes arrive whole.
   assign in_byte   = par_q ? {serial_out_or_parallel_bit7_i, parallel_data_pins_i} : {sh_q, si};
   assign byte_done = par_q | (bit_q == 3'h7);
   assign maker_device_id_cmd_sel  = (idx_q == 3'h3) ? in_byte[0] : alt_q;

   // Bit and byte counters and the command byte.
   always_ff @(posedge sclk or posedge frm_rst)
   begin
      if (frm_rst)
      begin
         bit_q <= 3'h0;
         idx_q <= 3'h0;
         sh_q  <= 7'h00;
         cmd_q <= 8'h00;
      end
      else
      begin
         bit_q <= par_q ? 3'h0 : bit_q + 3'h1;
         sh_q  <= {sh_q[5:0], si};
         if (byte_done)
         begin
            if (idx_q != 3'h7)
               idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h0)
               cmd_q <= in_byte;
         end
      end
   end

   // Address gathers high byte first; read streams on, program wraps in its page.
   always_ff @(posedge sclk or posedge frm_rst)
   begin
      if (frm_rst)
      begin
         addr_q  <= 24'h000000;
         wr_ok_q <= 1'b0;
      end
      else if (byte_done)
      begin
         if (arm_kind == SFP_OP_PROG)
            wr_ok_q <= 1'b1;
         case (idx_q)
            3'h1: addr_q[23:16] <= in_byte;
            3'h2: addr_q[15:8] <= in_byte;
            3'h3: addr_q <= (cmd_q == `SFP_READ_CMD) ? arr_addr + 24'h000001 : arr_addr;
            default:
            begin
               if (idx_q != 3'h0 && cmd_q == `SFP_PROG_CMD)
                  addr_q[7:0] <= addr_q[7:0] + 8'h01;
               else if (idx_q != 3'h0)
                  addr_q <= addr_q + 24'h000001;
            end
         endcase
      end
   end

   // Array strobes; parameter mode steers every access to the small area.
   assign arr_addr  = (idx_q == 3'h3) ? {addr_q[23:8], in_byte} : addr_q;
   assign arr_param = param_q;
   assign arr_rd    = byte_done && !dp_q && cmd_q == `SFP_READ_CMD && idx_q >= 3'h3;
   assign arr_we    = byte_done && wr_ok_q && idx_q >= 3'h4;
   assign arr_wdata = in_byte;

   // Output byte and driver enable.
   always_ff @(posedge sclk or posedge frm_rst)
   begin
      if (frm_rst)
      begin
         dout_q   <= 8'h00;
         oe_q     <= 1'b0;
         id_cnt_q <= 2'h0;
         alt_q    <= 1'b0;
      end
      else if (byte_done)
      begin
         if (idx_q == 3'h0 && !dp_q && in_byte == `SFP_READ_STATUS_CMD)
         begin
            dout_q <= sfp_status(lock_q, fail_s_q, bp_q, wel_q, busy_s_q);
            oe_q   <= 1'b1;
         end
         else if (idx_q == 3'h0 && !dp_q && in_byte == `SFP_READ_IDENTITY_CMD)
         begin
            dout_q   <= MAKER_ID;
            id_cnt_q <= 2'h1;
            oe_q     <= 1'b1;
         end
         else if (idx_q != 3'h0 && cmd_q == `SFP_READ_STATUS_CMD && !dp_q)
            dout_q <= sfp_status(lock_q, fail_s_q, bp_q, wel_q, busy_s_q);
         else if (idx_q != 3'h0 && cmd_q == `SFP_READ_IDENTITY_CMD && !dp_q)
         begin
            dout_q <= (id_cnt_q == 2'h1) ? MEM_TYPE : DENSITY;
            if (id_cnt_q != 2'h3)
               id_cnt_q <= id_cnt_q + 2'h1;
            else
               oe_q <= 1'b0;
         end
         else if (idx_q >= 3'h3 && !dp_q && cmd_q == `SFP_READ_CMD)
         begin
            dout_q <= arr_rdata;
            oe_q   <= 1'b1;
         end
         else if (idx_q >= 3'h3 && cmd_q == `SFP_WAKE_SIG_CMD)
         begin
            dout_q <= DEV_ID;
            oe_q   <= 1'b1;
         end
         else if (idx_q >= 3'h3 && !dp_q && cmd_q == `SFP_MAKER_DEV_ID_CMD)
         begin
            dout_q <= maker_device_id_cmd_sel ? DEV_ID : MAKER_ID;
            alt_q  <= ~maker_device_id_cmd_sel;
            oe_q   <= 1'b1;
         end
      end
      else
      begin
         dout_q <= {dout_q[6:0], 1'b0};
         if (idx_q == 3'h3 && bit_q == 3'h6 && !dp_q && sfp_late_out(cmd_q))
            oe_q <= 1'b1;
      end
   end

   // Serial data leaves on the falling edge so the host samples it cleanly.
   always_ff @(negedge sclk or posedge frm_rst)
   begin
      if (frm_rst)
         so_bit_q <= 1'b0;
      else
         so_bit_q <= dout_q[7];
   end

   // Pin drive; the parallel bus is driven only in parallel mode.
   assign serial_out_or_parallel_bit7_o  = par_q ? dout_q[7] : so_bit_q;
   assign serial_out_or_parallel_bit7_oe = oe_q;
   assign parallel_data_pins_o           = dout_q[6:0];
   assign parallel_data_pins_oe          = {7{oe_q & par_q}};

   // Selects the internal operation that a command byte accepts.
   always_comb
   begin
      arm_kind = SFP_OP_NONE;
      if (byte_done && wel_q && !busy_s_q && !dp_q)
      begin
         if (idx_q == 3'h0 && !param_q && (in_byte == `SFP_CHIP_ERASE_A_CMD || in_byte == `SFP_CHIP_ERASE_B_CMD))
            arm_kind = SFP_OP_CERASE;
         else if (idx_q == 3'h1 && !param_q && !lock_q && cmd_q == `SFP_WRITE_STATUS_CMD)
            arm_kind = SFP_OP_WSTAT;
         else if (idx_q == 3'h3 && (cmd_q == `SFP_SECT_ERASE_A_CMD || cmd_q == `SFP_SECT_ERASE_B_CMD))
            arm_kind = SFP_OP_SERASE;
         else if (idx_q == 3'h3 && cmd_q == `SFP_PROG_CMD)
            arm_kind = SFP_OP_PROG;
      end
   end
   assign arm = (arm_kind != SFP_OP_NONE);

   // Persistent mode and status state; only power-on reset clears it.
   always_ff @(posedge sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         par_q    <= 1'b0;
         param_q  <= 1'b0;
         wel_q    <= ST_RST[`SFP_ST_WEL];
         lock_q   <= 1'b0;
         bp_q     <= 3'h0;
         dp_q     <= 1'b0;
         tog_q    <= 1'b0;
         kind_q   <= SFP_OP_NONE;
         kparam_q <= 1'b0;
      end
      else
      begin
         if (byte_done && idx_q == 3'h0 && dp_q && in_byte == `SFP_WAKE_SIG_CMD)
            dp_q <= 1'b0;
         else if (byte_done && idx_q == 3'h0 && !dp_q)
         begin
            case (in_byte)
               `SFP_PARALLEL_CMD:    par_q <= 1'b1;
               `SFP_WRITE_EN_CMD:    wel_q <= 1'b1;
               `SFP_WRITE_DIS_CMD:   wel_q <= 1'b0;
               `SFP_DEEP_SLEEP_CMD:  dp_q <= 1'b1;
               `SFP_ENTER_PARAM_CMD: param_q <= busy_s_q ? param_q : 1'b1;
               `SFP_EXIT_PARAM_CMD:  param_q <= busy_s_q ? param_q : 1'b0;
               default:              dp_q <= dp_q;
            endcase
         end
         if (arm)
         begin
            tog_q    <= ~tog_q;
            kind_q   <= arm_kind;
            kparam_q <= (arm_kind == SFP_OP_CERASE) ? 1'b0 : param_q;
            wel_q    <= 1'b0;
            if (arm_kind == SFP_OP_WSTAT)
            begin
               lock_q <= in_byte[`SFP_ST_LOCK];
               bp_q   <= in_byte[`SFP_ST_BP_HI:`SFP_ST_BP_LO];
            end
         end
      end
   end

   // Sequencer busy and fail levels brought onto the link clock.
   always_ff @(posedge sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_m_q <= 1'b0;
         busy_s_q <= 1'b0;
         fail_m_q <= 1'b0;
         fail_s_q <= 1'b0;
      end
      else
      begin
         busy_m_q <= busy;
         busy_s_q <= busy_m_q;
         fail_m_q <= fail_q;
         fail_s_q <= fail_m_q;
      end
   end

   // ****************************************************************
   // Operation sequencer
   // ****************************************************************

   // Deselect and the request toggle cross onto the system clock.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cs_m_q  <= 1'b1;
         cs_s_q  <= 1'b1;
         tog_m_q <= 1'b0;
         tog_s_q <= 1'b0;
      end
      else
      begin
         cs_m_q  <= cs_n;
         cs_s_q  <= cs_m_q;
         tog_m_q <= tog_q;
         tog_s_q <= tog_m_q;
      end
   end

   // An armed operation starts once the host has deselected.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q     <= SFP_IDLE;
         cnt_q    <= 24'h000000;
         seen_q   <= 1'b0;
         fail_q   <= ST_RST[`SFP_ST_FAIL];
         start_q  <= 1'b0;
         op_kind  <= SFP_OP_NONE;
         op_param <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         case (st_q)
            SFP_IDLE:
            begin
               if (cs_s_q && tog_s_q != seen_q)
               begin
                  st_q     <= SFP_BUSY;
                  cnt_q    <= 24'(OP_CYC - 1);
                  seen_q   <= tog_s_q;
                  fail_q   <= 1'b0;
                  start_q  <= 1'b1;
                  op_kind  <= kind_q;
                  op_param <= kparam_q;
               end
            end
            SFP_BUSY:
            begin
               if (cnt_q == 24'h000000)
               begin
                  st_q   <= SFP_IDLE;
                  fail_q <= op_fail;
               end
               else
                  cnt_q <= cnt_q - 24'h000001;
            end
            default: st_q <= SFP_IDLE;
         endcase
      end
   end
   assign op_start = start_q;
   assign busy     = (st_q == SFP_BUSY);

   // ****************************************************************
   // Assertions
   // ****************************************************************

   property p_param_busy;
      @(posedge sclk) disable iff (sys_rst)
      (byte_done && idx_q == 3'h0 && busy_s_q && in_byte == `SFP_ENTER_PARAM_CMD) |=> param_q == $past(param_q);
   endproperty
   a_param_busy: assert property (p_param_busy) else $error("Parameter mode changed while busy.");

   property p_ce_param;
      @(posedge sclk) disable iff (sys_rst)
      (byte_done && idx_q == 3'h0 && param_q && (in_byte == `SFP_CHIP_ERASE_A_CMD || in_byte == `SFP_CHIP_ERASE_B_CMD))
      |=> tog_q == $past(tog_q);
   endproperty
   a_ce_param: assert property (p_ce_param) else $error("Chip erase accepted in parameter mode.");

   property p_ce_main;
      @(posedge ref_clk) disable iff (sys_rst)
      (op_start && op_kind == SFP_OP_CERASE) |-> !op_param ##1 !op_param;
   endproperty
   a_ce_main: assert property (p_ce_main) else $error("Chip erase aimed at parameter area.");

   property p_fail_set;
      @(posedge ref_clk) disable iff (sys_rst)
      $fell(busy) |-> fail_q == $past(op_fail);
   endproperty
   a_fail_set: assert property (p_fail_set) else $error("Fail flag does not follow result.");

   property p_fail_clr;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(busy) |-> !fail_q && op_start;
   endproperty
   a_fail_clr: assert property (p_fail_clr) else $error("Fail flag not cleared at start.");

   property p_par_stay;
      @(posedge sclk) disable iff (sys_rst)
      par_q |=> par_q;
   endproperty
   a_par_stay: assert property (p_par_stay) else $error("Parallel mode was left.");

   property p_stat_oe;
      @(posedge sclk) disable iff (frm_rst)
      (!par_q && !dp_q && idx_q == 3'h0 && bit_q == 3'h6) ##1 (in_byte == `SFP_READ_STATUS_CMD)
      |=> oe_q && dout_q[0] == $past(busy_s_q);
   endproperty
   a_stat_oe: assert property (p_stat_oe) else $error("Status output not enabled at eighth edge.");

   property p_early_oe;
      @(posedge sclk) disable iff (frm_rst)
      (!par_q && !dp_q && idx_q == 3'h3 && bit_q == 3'h5 && cmd_q == `SFP_READ_CMD) |=> !oe_q ##1 oe_q;
   endproperty
   a_early_oe: assert property (p_early_oe) else $error("Read output enable not one cycle early.");

   property p_id_len;
      @(posedge sclk) disable iff (frm_rst)
      (byte_done && cmd_q == `SFP_READ_IDENTITY_CMD && id_cnt_q == 2'h3) |=> !oe_q;
   endproperty
   a_id_len: assert property (p_id_len) else $error("Identity output ran past three bytes.");

   property p_maker_device_id_cmd;
      @(posedge sclk) disable iff (frm_rst)
      (byte_done && !dp_q && idx_q == 3'h3 && cmd_q == `SFP_MAKER_DEV_ID_CMD)
      |=> dout_q == ($past(in_byte[0]) ? DEV_ID : MAKER_ID);
   endproperty
   a_maker_device_id_cmd: assert property (p_maker_device_id_cmd) else $error("Wrong first identity byte.");

   c_read: cover property (@(posedge sclk) disable iff (frm_rst) arr_rd ##8 arr_rd);
   c_par_stat: cover property (@(posedge sclk) disable iff (frm_rst) par_q && cmd_q == `SFP_READ_STATUS_CMD && oe_q);
   c_op_done: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(busy) && fail_q);
endmodule
`default_nettype wire

// >>> testbench/sfp_host_model.sv
// Host controller model that drives the link clock, select and data pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model
(
   // Link pins toward the device.
   output logic             sclk,
   output logic             cs_n,
   output logic             si,
   output logic      [7:0]  pins,
   // Device side of the data pins.
   input  wire logic [7:0]  dev_o,
   input  wire logic [7:0]  dev_oe
);
   logic       hen = 1'b0;
   logic [7:0] hd  = 8'h00;
   logic       par = 1'b0;
   real        half = 7.5;

   // A released pin shows the inverse of its last level, so a stale value never reads as valid.
   always_comb
   begin
      for (int j = 0; j < 8; j++)
         pins[j] = dev_oe[j] ? dev_o[j] : (hen ? hd[j] : ~hd[j]);
   end

   // The link clock stays low and the device deselected outside frames.
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // Selects the device.
   task automatic open_frame();
      cs_n = 1'b0;
      #20;
   endtask

   // Deselects the device and lets go of the data lines.
   task automatic close_frame();
      #20;
      cs_n = 1'b1;
      si   = ~si;
      hen  = 1'b0;
      #200;
   endtask

   // Parallel mode runs the link clock below its reduced ceiling.
   task automatic go_parallel();
      par  = 1'b1;
      half = 420.0;
   endtask

   // Moves one byte: bit by bit on the serial lines, or whole on the pins in parallel mode.
   task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
      if (par)
      begin
         hd  = tx;
         hen = drv;
         #(half) sclk = 1'b1;
         rx  = pins;
         #(half) sclk = 1'b0;
      end
      else
         for (int i = 7; i >= 0; i--)
         begin
            si = tx[i];
            #(half) sclk = 1'b1;
            rx = {rx[6:0], pins[7]};
            #(half) sclk = 1'b0;
         end
   endtask
endmodule
`default_nettype wire

// >>> testbench/sfp_flash_cmd_test.sv
// Self-checking bench for the flash command interpreter.
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_cmd_test
   import sfp_pkg::*;
;
   localparam logic [7:0] MK = 8'h5a;  // Arbitrary value.
   localparam logic [7:0] DV = 8'h15;  // Arbitrary value.
   logic        ref_clk, sys_rst, op_fail, sclk, cs_n, si, b7_o, b7_oe;
   logic        arr_param, arr_rd, arr_we, op_start, op_param, busy, par_seen;
   logic [7:0]  pins, arr_rdata, arr_wdata, we_dat;
   logic [7:0]  got [4];
   logic [6:0]  pd_o, pd_oe;
   logic [23:0] arr_addr;
   sfp_op_t     op_kind;
   int          n_errors = 0, total_checks = 0, edges = 0, oe_at = 0, we_cnt = 0, st_cnt = 0;

   // Array contents follow the address and the area selected.
   assign arr_rdata = arr_addr[7:0] ^ arr_addr[15:8] ^ {arr_param, 7'h00};

   sfp_flash_cmd #(.OP_CYC(20), .MAKER_ID(MK), .MEM_TYPE(8'h3c), .DENSITY(8'h16), .DEV_ID(DV)) sfp_flash_cmd_inst
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .si(si),
      .serial_out_or_parallel_bit7_i(pins[7]), .serial_out_or_parallel_bit7_o(b7_o),
      .serial_out_or_parallel_bit7_oe(b7_oe), .parallel_data_pins_i(pins[6:0]),
      .parallel_data_pins_o(pd_o), .parallel_data_pins_oe(pd_oe), .arr_addr(arr_addr),
      .arr_param(arr_param), .arr_rd(arr_rd), .arr_rdata(arr_rdata), .arr_we(arr_we),
      .arr_wdata(arr_wdata), .op_start(op_start), .op_kind(op_kind), .op_param(op_param),
      .op_fail(op_fail), .busy(busy)
   );

   sfp_host_model sfp_host_model_inst
   (
      .sclk(sclk), .cs_n(cs_n), .si(si), .pins(pins), .dev_o({b7_o, pd_o}), .dev_oe({b7_oe, pd_oe})
   );

   // System clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Link monitor: edge count, first driven edge and array strobes.
   always @(posedge sclk)
   begin
      edges++;
      if (arr_rd === 1'b1)
         par_seen = arr_param;
      if (arr_we === 1'b1)
      begin
         we_cnt++;
         we_dat = arr_wdata;
      end
      #1;
      if (b7_oe === 1'b1 && oe_at == 0)
         oe_at = edges;
   end

   // Counts operation starts.
   always @(posedge ref_clk)
      if (op_start === 1'b1)
         st_cnt++;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One frame: opcode, address bytes high first, then data bytes driven or read back.
   task automatic do_cmd(input logic [7:0] op, input logic [23:0] a, input int na, input int nd, input logic drv);
      logic [7:0] r;
      edges = 0;
      oe_at = 0;
      sfp_host_model_inst.open_frame();
      sfp_host_model_inst.xfer(op, 1'b1, r);
      for (int i = 0; i < na; i++)
         sfp_host_model_inst.xfer(a[23 - 8 * i -: 8], 1'b1, r);
      for (int i = 0; i < nd; i++)
         sfp_host_model_inst.xfer(8'hc3 + 8'(i), drv, got[i]);
      sfp_host_model_inst.close_frame();
   endtask

   task automatic status(input logic [7:0] exp);
      do_cmd(8'h05, 24'h0, 0, 1, 1'b0);
      chk("status", exp, got[0]);
   endtask

   // Waits for the busy level under a bounded count.
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 500)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (busy !== lvl)
      begin
         $display("BAD busy expected %b seen %b", lvl, busy);
         n_errors++;
         final_report();
      end
   endtask

   // Program with a failing then a passing operation, with an enter attempt while busy.
   task automatic t_program();
      @(posedge ref_clk) op_fail <= 1'b1;
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      status(8'h02);
      do_cmd(8'h02, 24'h0001f0, 3, 1, 1'b1);
      chk("write strobes", 8'd1, 8'(we_cnt));
      chk("write data", 8'hc3, we_dat);
      wait_busy(1'b1);
      chk("op kind", 8'(SFP_OP_PROG), 8'(op_kind));
      status(8'h01);
      wait_busy(1'b0);
      status(8'h40);
      @(posedge ref_clk) op_fail <= 1'b0;
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h02, 24'h000010, 3, 1, 1'b1);
      wait_busy(1'b1);
      status(8'h01);
      do_cmd(8'ha5, 24'h0, 0, 0, 1'b1);
      wait_busy(1'b0);
      status(8'h00);
      do_cmd(8'h03, 24'h0, 3, 1, 1'b0);
      chk("param after busy enter", 8'h00, 8'(par_seen));
      $display("done program");
   endtask

   // Serial read across a page edge, identity and maker/device order.
   task automatic t_read();
      do_cmd(8'h03, 24'h1234fe, 3, 3, 1'b0);
      chk("read oe edge", 8'd31, 8'(oe_at));
      chk("read byte 0", 8'hfe ^ 8'h34, got[0]);
      chk("read byte 1", 8'hff ^ 8'h34, got[1]);
      chk("read byte 2", 8'h00 ^ 8'h35, got[2]);
      do_cmd(8'h9f, 24'h0, 0, 4, 1'b0);
      chk("ident stop", 8'hff, got[3]);
      chk("read_identity_cmd oe edge", 8'd8, 8'(oe_at));
      chk("ident maker", MK, got[0]);
      chk("ident type", 8'h3c, got[1]);
      chk("ident density", 8'h16, got[2]);
      for (int k = 0; k < 2; k++)
      begin
         do_cmd(8'h90, 24'(k), 3, 2, 1'b0);
         chk("maker_device_id_cmd first", k ? DV : MK, got[0]);
         chk("maker_device_id_cmd second", k ? MK : DV, got[1]);
      end
      $display("done read");
   endtask

   // Parameter mode steers reads and refuses chip erase and status write.
   task automatic t_param();
      int s0;
      do_cmd(8'ha5, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h03, 24'h000005, 3, 1, 1'b0);
      chk("param read flag", 8'h01, 8'(par_seen));
      chk("param read data", 8'h85, got[0]);
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h02, 24'h000005, 3, 1, 1'b1);
      wait_busy(1'b1);
      chk("param program area", 8'h01, 8'(op_param));
      wait_busy(1'b0);
      s0 = st_cnt;
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h60, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h01, 24'h0, 0, 1, 1'b1);
      repeat (10) @(negedge ref_clk);
      chk("refused starts", 8'(s0), 8'(st_cnt));
      do_cmd(8'h04, 24'h0, 0, 0, 1'b1);
      do_cmd(8'hb5, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h03, 24'h000005, 3, 1, 1'b0);
      chk("normal read flag", 8'h00, 8'(par_seen));
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      do_cmd(8'hc7, 24'h0, 0, 0, 1'b1);
      wait_busy(1'b1);
      chk("erase kind", 8'(SFP_OP_CERASE), 8'(op_kind));
      chk("erase area", 8'h00, 8'(op_param));
      wait_busy(1'b0);
      $display("done param");
   endtask

   // Parallel mode: whole bytes per clock, status, wake with signature, no way back.
   task automatic t_parallel();
      do_cmd(8'h55, 24'h0, 0, 0, 1'b1);
      sfp_host_model_inst.go_parallel();
      status(8'h00);
      chk("par oe edge", 8'd1, 8'(oe_at));
      do_cmd(8'hb9, 24'h0, 0, 0, 1'b1);
      do_cmd(8'hab, 24'h0, 3, 1, 1'b0);
      chk("par signature", DV, got[0]);
      status(8'h00);
      chk("still parallel", 8'd1, 8'(oe_at));
      do_cmd(8'h06, 24'h0, 0, 0, 1'b1);
      do_cmd(8'h01, 24'h0, 0, 1, 1'b1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      status(8'h80);
      $display("done parallel");
   endtask

   // Main sequence.
   initial
   begin
      sys_rst = 1'b1;
      op_fail = 1'b0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      status(8'h00);
      chk("read_status_cmd oe edge", 8'd8, 8'(oe_at));
      t_program();
      t_read();
      t_param();
      t_parallel();
      final_report();
   end
endmodule
`default_nettype wire
